// file: rtl/trb_consts.vh
// Constants for the timer register bank
`ifndef TRB_CONSTS_VH
`define TRB_CONSTS_VH
`define TRB_BANK_D 4'hd
`define TRB_GEN_LO 8'h04
`define TRB_CTL_LO 8'hf0
`define TRB_OFF_CTLA 4'h0
`define TRB_OFF_CTLB 4'h1
`define TRB_OFF_CTLC 4'h2
`define TRB_OFF_CTLD 4'h3
`define TRB_OFF_RL8L 4'h4
`define TRB_OFF_RL8H 4'h5
`define TRB_OFF_H16L 4'h6
`define TRB_OFF_H16H 4'h7
`define TRB_OFF_C16L 4'h8
`define TRB_OFF_C16H 4'h9
`define TRB_OFF_C8L 4'ha
`define TRB_OFF_C8H 4'hb
`define TRB_CTLA_EN 7
`define TRB_CTLA_MODE 6
`define TRB_CTLA_TOUT 5
`define TRB_CTLA_MASK 1
`define TRB_CTLA_PSEL 0
`define TRB_RST_CTLA 8'h00
`define TRB_RST_CTLB 8'h00
`define TRB_RST_CTLC 8'h00
`define TRB_RST_CTLD 8'h1f
`define TRB_RST_DATA 8'h00
`define TRB_KEEP_CTLA 8'h3e
`define TRB_KEEP_CTLB 8'h30
`define TRB_KEEP_CTLC 8'h3c
`define TRB_KEEP_CTLD 8'h00
`endif

// file: rtl/trb_timer8.v
// Eight-bit down counter with reload and single-pass modes
`timescale 1ns/1ps
`include "trb_consts.vh"
module trb_timer8 (
  input wire clock_i, // Core clock
  input wire reset_n_i, // Async reset, active low
  input wire start_i, // Start pulse from enable write
  input wire tick_i, // Synchronised count tick
  input wire single_i, // 1 single-pass, 0 modulo-N
  input wire [7:0] low_i, // Count loaded when output low
  input wire [7:0] high_i, // Count loaded when output high
  output reg run_o, // Counting
  output reg out_o, // Timer output level
  output reg tc_o // Terminal count pulse
);
  reg [7:0] count_reg;

  // Count down on ticks, toggle at terminal count, reload unless single-pass
  always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count_reg <= 8'h00;
      run_o <= 1'b0;
      out_o <= 1'b0;
      tc_o <= 1'b0;
    end else begin
      tc_o <= 1'b0;
      if (start_i) begin
        run_o <= 1'b1;
        out_o <= 1'b0;
        count_reg <= low_i;
      end else if (run_o && tick_i) begin
        if (count_reg == 8'h00) begin
          tc_o <= 1'b1;
          out_o <= ~out_o;
          if (single_i) begin
            run_o <= 1'b0;
          end else begin
            count_reg <= out_o ? low_i : high_i;
          end
        end else begin
          count_reg <= count_reg - 8'h01;
        end
      end
    end
  end
endmodule // trb_timer8

// file: rtl/trb_bank.v
// Register bank for the counter/timers in expanded bank D
`timescale 1ns/1ps
`include "trb_consts.vh"
module trb_bank (
  input wire clock_i, // Core clock
  input wire reset_n_i, // Power-on reset, active low
  input wire recover_i, // Stop-mode recovery pulse, core domain
  input wire [7:0] register_pointer_i, // Register pointer value
  input wire [7:0] addr_i, // Register address from core
  input wire wr_i, // Write strobe
  input wire rd_i, // Read strobe
  input wire [7:0] wdata_i, // Write data
  input wire timer_clk_i, // Timer count input pin
  input wire meas_i, // Measured input pin
  input wire cap16_i, // Capture strobe for 16-bit value
  input wire [15:0] cap16_val_i, // 16-bit value to capture
  input wire port_out_i, // Ordinary port output level
  output reg [7:0] rdata_o, // Read data
  output reg hit_o, // Address falls in timer bank
  output reg timer_output_pin_o, // Pin level
  output reg irq_o // Timeout interrupt request pulse
);
  reg [7:0] ctla_reg;
  reg [7:0] ctlb_reg;
  reg [7:0] ctlc_reg;
  reg [7:0] ctld_reg;
  reg [7:0] rl8l_reg;
  reg [7:0] rl8h_reg;
  reg [7:0] h16l_reg;
  reg [7:0] h16h_reg;
  reg [7:0] c16l_reg;
  reg [7:0] c16h_reg;
  reg [7:0] c8l_reg;
  reg [7:0] c8h_reg;
  reg [7:0] cnt8_reg;
  reg tclk_s1_reg;
  reg tclk_s2_reg;
  reg tclk_s3_reg;
  reg meas_s1_reg;
  reg meas_s2_reg;
  reg meas_s3_reg;
  wire tick;
  wire start;
  wire run;
  wire tout;
  wire tc;
  wire sel;
  wire [3:0] off;

  // Bank hit: working-register access with pointer selecting bank D
  function is_bank;
    input [7:0] rp;
    input [7:0] a;
    begin
      is_bank = (rp[3:0] == `TRB_BANK_D) && (a[7:4] == rp[7:4]) &&
        (a < `TRB_CTL_LO);
    end
  endfunction

  assign sel = is_bank(register_pointer_i, addr_i);
  assign off = addr_i[3:0];
  assign tick = tclk_s2_reg & ~tclk_s3_reg;
  assign start = wr_i && sel && (off == `TRB_OFF_CTLA) &&
    wdata_i[`TRB_CTLA_EN];

  // Pin synchronisers, first stage read only by second
  always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      tclk_s1_reg <= 1'b0;
      tclk_s2_reg <= 1'b0;
      tclk_s3_reg <= 1'b0;
      meas_s1_reg <= 1'b0;
      meas_s2_reg <= 1'b0;
      meas_s3_reg <= 1'b0;
    end else begin
      tclk_s1_reg <= timer_clk_i;
      tclk_s2_reg <= tclk_s1_reg;
      tclk_s3_reg <= tclk_s2_reg;
      meas_s1_reg <= meas_i;
      meas_s2_reg <= meas_s1_reg;
      meas_s3_reg <= meas_s2_reg;
    end
  end

  trb_timer8 u_timer8 (
    .clock_i(clock_i),
    .reset_n_i(reset_n_i),
    .start_i(start),
    .tick_i(tick),
    .single_i(ctla_reg[`TRB_CTLA_MODE]),
    .low_i(rl8l_reg),
    .high_i(rl8h_reg),
    .run_o(run),
    .out_o(tout),
    .tc_o(tc)
  );

  // Control registers; recovery keeps only the listed bits
  always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      ctla_reg <= `TRB_RST_CTLA;
      ctlb_reg <= `TRB_RST_CTLB;
      ctlc_reg <= `TRB_RST_CTLC;
      ctld_reg <= `TRB_RST_CTLD;
    end else if (recover_i) begin
      ctla_reg <= (ctla_reg & `TRB_KEEP_CTLA) |
        (`TRB_RST_CTLA & ~`TRB_KEEP_CTLA);
      ctlb_reg <= (ctlb_reg & `TRB_KEEP_CTLB) |
        (`TRB_RST_CTLB & ~`TRB_KEEP_CTLB);
      ctlc_reg <= (ctlc_reg & `TRB_KEEP_CTLC) |
        (`TRB_RST_CTLC & ~`TRB_KEEP_CTLC);
      ctld_reg <= `TRB_RST_CTLD;
    end else begin
      if (wr_i && sel && off == `TRB_OFF_CTLA) begin
        ctla_reg[4:0] <= wdata_i[4:0];
        ctla_reg[`TRB_CTLA_MODE] <= wdata_i[`TRB_CTLA_MODE];
      end
      ctla_reg[`TRB_CTLA_EN] <= run;
      // Set wins over a write-one clear in the same cycle
      if (tc) begin
        ctla_reg[`TRB_CTLA_TOUT] <= 1'b1;
      end else if (wr_i && sel && off == `TRB_OFF_CTLA &&
          wdata_i[`TRB_CTLA_TOUT]) begin
        ctla_reg[`TRB_CTLA_TOUT] <= 1'b0;
      end
      if (wr_i && sel && off == `TRB_OFF_CTLB) begin
        ctlb_reg <= wdata_i;
      end
      if (wr_i && sel && off == `TRB_OFF_CTLC) begin
        ctlc_reg <= wdata_i;
      end
      if (wr_i && sel && off == `TRB_OFF_CTLD) begin
        ctld_reg <= wdata_i;
      end
    end
  end

  // Hold and reload registers, untouched by recovery
  always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rl8l_reg <= `TRB_RST_DATA;
      rl8h_reg <= `TRB_RST_DATA;
      h16l_reg <= `TRB_RST_DATA;
      h16h_reg <= `TRB_RST_DATA;
    end else if (wr_i && sel) begin
      case (off)
        `TRB_OFF_RL8L: rl8l_reg <= wdata_i;
        `TRB_OFF_RL8H: rl8h_reg <= wdata_i;
        `TRB_OFF_H16L: h16l_reg <= wdata_i;
        `TRB_OFF_H16H: h16h_reg <= wdata_i;
        default: rl8l_reg <= rl8l_reg;
      endcase
    end
  end

  // Captures: software writes ignored, recovery keeps them
  always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      c16l_reg <= `TRB_RST_DATA;
      c16h_reg <= `TRB_RST_DATA;
      c8l_reg <= `TRB_RST_DATA;
      c8h_reg <= `TRB_RST_DATA;
      cnt8_reg <= 8'h00;
    end else begin
      if (cap16_i) begin
        c16h_reg <= cap16_val_i[15:8];
        c16l_reg <= cap16_val_i[7:0];
      end
      if (meas_s2_reg != meas_s3_reg) begin
        cnt8_reg <= 8'h00;
        if (meas_s3_reg) begin
          c8h_reg <= cnt8_reg;
        end else begin
          c8l_reg <= cnt8_reg;
        end
      end else if (tick && cnt8_reg != 8'hff) begin
        cnt8_reg <= cnt8_reg + 8'h01;
      end
    end
  end

  // Read mux, pin select and interrupt
  always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rdata_o <= 8'h00;
      hit_o <= 1'b0;
      timer_output_pin_o <= 1'b0;
      irq_o <= 1'b0;
    end else begin
      hit_o <= sel && (rd_i || wr_i);
      irq_o <= tc && ctla_reg[`TRB_CTLA_MASK];
      timer_output_pin_o <= ctla_reg[`TRB_CTLA_PSEL] ? tout :
        port_out_i;
      if (rd_i && sel) begin
        case (off)
          `TRB_OFF_CTLA: rdata_o <= ctla_reg;
          `TRB_OFF_CTLB: rdata_o <= ctlb_reg;
          `TRB_OFF_CTLC: rdata_o <= ctlc_reg;
          `TRB_OFF_CTLD: rdata_o <= ctld_reg;
          `TRB_OFF_RL8L: rdata_o <= rl8l_reg;
          `TRB_OFF_RL8H: rdata_o <= rl8h_reg;
          `TRB_OFF_H16L: rdata_o <= h16l_reg;
          `TRB_OFF_H16H: rdata_o <= h16h_reg;
          `TRB_OFF_C16L: rdata_o <= c16l_reg;
          `TRB_OFF_C16H: rdata_o <= c16h_reg;
          `TRB_OFF_C8L: rdata_o <= c8l_reg;
          `TRB_OFF_C8H: rdata_o <= c8h_reg;
          default: rdata_o <= 8'h00;
        endcase
      end
    end
  end
endmodule // trb_bank

// file: sim/trb_assertions.sv
// Port checker for the timer register bank
`timescale 1ns/1ps
module trb_assert (
  input wire clock_i, // Clock
  input wire reset_n_i, // Reset
  input wire recover_i, // Recovery
  input wire [7:0] register_pointer_i, // Pointer
  input wire [7:0] addr_i, // Address
  input wire wr_i, // Write
  input wire rd_i, // Read
  input wire [7:0] wdata_i, // Data in
  input wire timer_clk_i, // Tick pin
  input wire meas_i, // Measured pin
  input wire cap16_i, // Capture
  input wire [15:0] cap16_val_i, // Capture value
  input wire port_out_i, // Port level
  input wire [7:0] rdata_o, // Data out
  input wire hit_o, // Hit
  input wire timer_output_pin_o, // Pin
  input wire irq_o // Interrupt
);
  reg psel_q;
  reg mask_q;
  reg [15:0] c16_q;
  // Access that decodes into bank D of the current group
  wire sel = (wr_i | rd_i) && register_pointer_i[3:0] == 4'hd &&
    addr_i[7:4] == register_pointer_i[7:4] && addr_i < 8'hf0;
  wire ctl_wr = wr_i && sel && addr_i[3:0] == 4'h0;
  // Shadows of pin select, mask and 16-bit capture
  always @(posedge clock_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      psel_q <= 1'b0;
      mask_q <= 1'b0;
      c16_q <= 16'h0000;
    end else begin
      if (cap16_i)
        c16_q <= cap16_val_i;
      if (recover_i)
        psel_q <= 1'b0;
      else if (ctl_wr) begin
        psel_q <= wdata_i[0];
        mask_q <= wdata_i[1];
      end
    end
  end
  default clocking @(posedge clock_i); endclocking
  default disable iff (!reset_n_i);
  a_hit_decode: assert property (sel |=> hit_o)
    else $error("no hit after bank access");
  a_miss_quiet: assert property (!sel |=> !hit_o)
    else $error("hit without bank access");
  a_unmapped_zero: assert property (rd_i && sel && addr_i[3:0] > 4'hb
    |=> rdata_o == 8'h00) else $error("unmapped read not zero");
  a_rdata_hold: assert property (!(rd_i && sel) |=> $stable(rdata_o))
    else $error("read data moved without read");
  a_cap16_high: assert property (rd_i && sel && addr_i[3:0] == 4'h9
    && !cap16_i |=> rdata_o == c16_q[15:8]) else $error("bad capture msb");
  a_pin_port: assert property (!psel_q
    |=> timer_output_pin_o == $past(port_out_i)) else $error("pin not port");
  a_irq_masked: assert property (!mask_q [*3] |-> !irq_o)
    else $error("interrupt while masked");
  a_irq_pulse: assert property (irq_o |=> !irq_o)
    else $error("interrupt longer than one cycle");
  c_irq: cover property (irq_o);
  c_cap_read: cover property (rd_i && sel && addr_i[3:0] == 4'h9);
  c_miss: cover property (wr_i && !sel);
endmodule // trb_assert

bind trb_bank trb_assert u_chk (.clock_i(clock_i), .reset_n_i(reset_n_i),
  .recover_i(recover_i), .register_pointer_i(register_pointer_i),
  .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i),
  .timer_clk_i(timer_clk_i), .meas_i(meas_i), .cap16_i(cap16_i),
  .cap16_val_i(cap16_val_i), .port_out_i(port_out_i), .rdata_o(rdata_o),
  .hit_o(hit_o), .timer_output_pin_o(timer_output_pin_o), .irq_o(irq_o));

// file: sim/testbench.sv
// Self-checking bench for the timer register bank
`timescale 1ns/1ps
module testbench;
  reg clk = 1'b0;
  reg rst_n = 1'b0;
  reg rec = 1'b0;
  reg [7:0] ptr = 8'h0d;
  reg [7:0] addr = 8'h00;
  reg wr = 1'b0;
  reg rd = 1'b0;
  reg [7:0] wd = 8'h00;
  reg tclk = 1'b0;
  reg meas = 1'b0;
  reg cap = 1'b0;
  reg [15:0] cval = 16'h0000;
  reg pout = 1'b0;
  reg pout_q = 1'b0;
  wire pin;
  reg tick_on = 1'b0;
  reg [1:0] cnt = 2'h0;
  reg [31:0] seed = 32'h965f;
  reg [7:0] img [0:11];
  reg [7:0] v;
  reg [15:0] v16;
  wire [7:0] rdata;
  wire hit;
  wire irq;
  integer n_fail = 0;
  integer num_checks = 0;
  integer i;
  integer m;
  trb_bank dut (.clock_i(clk), .reset_n_i(rst_n), .recover_i(rec),
    .register_pointer_i(ptr), .addr_i(addr), .wr_i(wr), .rd_i(rd),
    .wdata_i(wd), .timer_clk_i(tclk), .meas_i(meas), .cap16_i(cap),
    .cap16_val_i(cval), .port_out_i(pout), .rdata_o(rdata), .hit_o(hit),
    .timer_output_pin_o(pin), .irq_o(irq));
  function [31:0] nx(input [31:0] s);
    nx = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Value a register shows after stop-mode recovery
  function [7:0] rec_val(input [3:0] o, input [7:0] d);
    case (o)
      4'h0: rec_val = d & 8'h3e;
      4'h1: rec_val = d & 8'h30;
      4'h2: rec_val = d & 8'h3c;
      4'h3: rec_val = 8'h1f;
      default: rec_val = d;
    endcase
  endfunction
  always #2 clk = ~clk;
  // Random pins and a slow count tick
  always @(posedge clk) begin
    seed <= nx(seed);
    pout <= seed[3];
    pout_q <= pout;
    meas <= seed[7];
    cnt <= cnt + 2'h1;
    if (tick_on && cnt == 2'h0)
      tclk <= ~tclk;
  end
  task chk(input [7:0] o, input [7:0] e, input [7:0] g);
    begin
      num_checks = num_checks + 1;
      if (g !== e) begin
        n_fail = n_fail + 1;
        $display("Error reg %h expected %h seen %h", o, e, g);
      end
    end
  endtask
  // One register cycle; a read compares with d
  task acc(input w, input [3:0] o, input [7:0] d);
    begin
      @(posedge clk);
      addr <= {ptr[7:4], o};
      wr <= w;
      rd <= !w;
      wd <= d;
      @(posedge clk);
      wr <= 1'b0;
      rd <= 1'b0;
      #1;
      if (!w)
        chk({4'h0, o}, d, rdata);
    end
  endtask
  task wait_irq(input [7:0] n);
    begin
      m = 0;
      for (i = 0; i < 2000 && m < n; i = i + 1) begin
        @(posedge clk);
        #1;
        if (irq === 1'b1)
          m = m + 1;
      end
      chk(8'haa, n, m[7:0]);
    end
  endtask
  task wrap_up;
    begin
      if (n_fail == 0 && num_checks > 0)
        $display("Result: passed");
      else
        $display("Result: failed");
      $finish;
    end
  endtask
  // Watchdog against a hang
  initial begin
    repeat (30000) @(posedge clk);
    n_fail = n_fail + 1;
    wrap_up;
  end
  // Main sequence
  initial begin
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    for (i = 0; i < 16; i = i + 1)
      acc(1'b0, i, (i == 3) ? 8'h1f : 8'h00);
    chk(8'hb0, {7'h0, pout_q}, {7'h0, pin});
    for (i = 1; i < 12; i = i + 1) begin
      v = seed[7:0];
      ptr <= {1'b0, seed[10:8], 4'hd};
      img[i] = (i > 7) ? 8'h00 : v;
      acc(1'b1, i, v);
    end
    for (i = 1; i < 12; i = i + 1)
      acc(1'b0, i, img[i]);
    for (m = 0; m < 2; m = m + 1) begin
      ptr <= m ? 8'hfd : 8'h0c;
      acc(1'b1, 4'h4, ~img[4]);
      chk(8'hee, 8'h00, {7'h0, hit});
    end
    ptr <= 8'h0d;
    acc(1'b0, 4'h4, img[4]);
    img[0] = 8'h03;
    acc(1'b1, 4'h0, img[0]);
    rec <= 1'b1;
    @(posedge clk);
    rec <= 1'b0;
    for (i = 0; i < 12; i = i + 1)
      acc(1'b0, i, rec_val(i, img[i]));
    v16 = seed[23:8];
    cval <= v16;
    cap <= 1'b1;
    @(posedge clk);
    cap <= 1'b0;
    acc(1'b0, 4'h8, v16[7:0]);
    acc(1'b0, 4'h9, v16[15:8]);
    acc(1'b1, 4'h4, 8'h03);
    acc(1'b1, 4'h5, 8'h03);
    acc(1'b1, 4'h0, 8'h22);
    tick_on <= 1'b1;
    acc(1'b1, 4'h0, 8'hc2);
    wait_irq(8'h01);
    acc(1'b0, 4'h0, 8'h62);
    acc(1'b1, 4'h0, 8'h42);
    acc(1'b0, 4'h0, 8'h62);
    acc(1'b1, 4'h0, 8'h62);
    acc(1'b0, 4'h0, 8'h42);
    acc(1'b1, 4'h0, 8'h82);
    wait_irq(8'h02);
    acc(1'b0, 4'h0, 8'ha2);
    tick_on <= 1'b0;
    wrap_up;
  end
endmodule // testbench
